// ===== common/port_pad_params.svh
`ifndef PORT_PAD_PARAMS_SVH
`define PORT_PAD_PARAMS_SVH

// Byte addresses of the two registers on the APB window.
`define PULLUP_OFFSET 12'h000
`define DRIVE_OFFSET 12'h004

// Values after reset.
`define PULLUP_RESET 8'h00
`define DRIVE_RESET 8'h00

// Pin mask for the port E pullup enable: pins 3, 2 and 0.
`define PORT_E_PULL_MASK 8'h0D

// Bit positions in the drive strength register.
`define DRIVE_BIT_A_B 0
`define DRIVE_BIT_C 1
`define DRIVE_BIT_D 2
`define DRIVE_BIT_E 3
`define DRIVE_BIT_F 4
`define DRIVE_BIT_G 5
`define DRIVE_BIT_H 6
`define DRIVE_BIT_J 7

`endif

// ===== common/port_pad_pkg.sv
package port_pad_pkg;

	// Port index in the pullup enable register and in the pin arrays.
	typedef enum logic [2:0] {
		port_a = 3'h0,
		port_b = 3'h1,
		port_c = 3'h2,
		port_d = 3'h3,
		port_e = 3'h4,
		port_f = 3'h5,
		port_g = 3'h6,
		port_h = 3'h7
	} port_index_type;

	// One register value.
	typedef logic [7:0] reg_byte_type;

	// One control bit per pin for ports A to H.
	typedef logic [7:0][7:0] pin_matrix_type;

endpackage

// ===== hdl/port_pad_pullup_drive_control.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "port_pad_params.svh"

//Contract
//- Both registers vanish from the map while the chip is in peripheral mode.
//- Pullup register is read and written any time it is mapped.
//- A set pullup enable acts only on pins currently configured as inputs.
//- Ports A B C D F G H each have one pullup bit.
//- Port E pullup bit acts only on input pins 3, 2 and 0.
//- Pullups of port C or D stay off while it carries the data bus.
//- Pullups of port A or B stay off while it carries the address bus.
//- Drive register readable whenever mapped; writes ignored in special modes.
//- Ports C D E F G H J each have one reduced drive bit.
//- One shared drive bit sets reduced drive for ports A and B.
//- Reduced drive applies whatever function the output pin performs.
module port_pad_pullup_drive_control
	import port_pad_pkg::*;
(
	input wire logic pclk, // APB clock, 50 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped access.
	input wire logic peripheral_mode, // Chip is in peripheral mode.
	input wire logic special_mode, // Chip is in a special mode.
	input wire logic [7:0][7:0] pin_is_output, // Direction per pin, A..H.
	input wire logic address_bus_a, // Port A carries the address bus.
	input wire logic address_bus_b, // Port B carries the address bus.
	input wire logic data_bus_c, // Port C carries the data bus.
	input wire logic data_bus_d, // Port D carries the data bus.
	output logic [7:0][7:0] pullup_pin, // Pullup on per pin, A..H.
	output logic [8:0] low_drive_port // Reduced drive, A B C D E F G H J.
);

	// Software registers, held in the low byte of their bus words.
	reg_byte_type port_pullup_enables;
	reg_byte_type port_drive_strength;
	// Decode held from the setup cycle to the completing access edge.
	logic hit_pullup;
	logic hit_drive;
	// Phase qualifiers of the current transfer.
	logic access_done;
	logic setup_phase;
	// Pin side: external bus use per port and the per-pin pullup mask.
	logic [7:0] bus_use;
	logic [7:0][7:0] pull_mask;
	// Address decode of the request in its setup cycle.
	logic setup_pullup;
	logic setup_drive;

	// The setup cycle is where address and peripheral mode are judged; the
	// access edge adds only the special mode lock, so a peripheral mode change
	// between the two cannot split one transfer into half a write.
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready;

	// Address decode in the setup phase; peripheral mode hides both.
	// Any other address, and both addresses in peripheral mode, fall
	// through to an error answer with zero read data.
	// peripheral mode unmaps
	assign setup_pullup = !peripheral_mode && paddr == `PULLUP_OFFSET;
	assign setup_drive = !peripheral_mode && paddr == `DRIVE_OFFSET;

	// No wait state: the answer is prepared at the setup edge.
	// Registering the answer keeps every bus output on a flip-flop at no
	// cost in cycles; no transfer ever needs more than one access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	// Decode is latched so the write uses the same answer that was given.
	// A peripheral mode change during the access cycle therefore cannot
	// turn an error answer into a silent write, or the reverse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hit_pullup <= 1'b0;
			hit_drive <= 1'b0;
		end else if (setup_phase) begin
			hit_pullup <= setup_pullup;
			hit_drive <= setup_drive;
		end
	end

	// Read data and error; an unmapped address reads zero.
	// Outside the access cycle both lines return to zero, so a stale
	// value can never be taken for the answer to the next transfer.
	// unmapped access errors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			pslverr <= !(setup_pullup || setup_drive);
			if (!pwrite && setup_pullup) begin
				prdata <= {24'h00_0000, port_pullup_enables};
			end else if (!pwrite && setup_drive) begin
				prdata <= {24'h00_0000, port_drive_strength};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end else begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// Pullup enables take writes with no special mode restriction.
	// Only the low byte of the bus word is kept; the upper bits of the
	// write are dropped and read back as zero.
	// unrestricted pullup write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_pullup_enables <= `PULLUP_RESET;
		end else if (access_done && pwrite && hit_pullup) begin
			port_pullup_enables <= pwdata[7:0];
		end
	end

	// Drive selects lock in special modes; the write is dropped silently
	// so that test software sees no bus error.
	// Reads stay possible in every mode that maps the register.
	// special mode blocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_drive_strength <= `DRIVE_RESET;
		end else if (access_done && pwrite && hit_drive && !special_mode) begin
			port_drive_strength <= pwdata[7:0];
		end
	end

	// Ports whose pins carry the external buses ignore their enable.
	// Ports E to H never carry a bus here, so their bits are tied off.
	// data bus override
	assign bus_use = {4'h0, data_bus_d, data_bus_c, address_bus_b,
		address_bus_a};

	// One pullup control per port, gated by direction and bus use.
	// The enable is registered with the pin direction, so a pullup
	// follows a direction change one edge later; the pad sees no glitch
	// because every pin control comes straight from a flip-flop.
	genvar p;
	generate
		for (p = 0; p < 8; p++) begin : g_port
			// Port E only has pullups behind pins 3, 2 and 0.
			// port E pins
			assign pull_mask[p] = (p == 4) ? `PORT_E_PULL_MASK : 8'hFF;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pullup_pin[p] <= 8'h00;
				end else if (port_pullup_enables[p] && !bus_use[p]) begin
					pullup_pin[p] <= ~pin_is_output[p] & pull_mask[p];
				end else begin
					pullup_pin[p] <= 8'h00;
				end
			end
		end
	endgenerate

	// Drive selects do not look at direction or pin function at all.
	// The shared select for ports A and B is fanned out to both outputs
	// so that the pad ring sees one control line per port.
	// per port drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_drive_port <= 9'h000;
		end else begin
			low_drive_port <= {
				port_drive_strength[`DRIVE_BIT_J],
				port_drive_strength[`DRIVE_BIT_H],
				port_drive_strength[`DRIVE_BIT_G],
				port_drive_strength[`DRIVE_BIT_F],
				port_drive_strength[`DRIVE_BIT_E],
				port_drive_strength[`DRIVE_BIT_D],
				port_drive_strength[`DRIVE_BIT_C],
				port_drive_strength[`DRIVE_BIT_A_B],
				port_drive_strength[`DRIVE_BIT_A_B]};
		end
	end

	// Checks run on the bus clock and are silent while reset is held.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	unmapped_write_a: assert property (
		access_done && pwrite && !hit_pullup && !hit_drive
		|=> $stable(port_pullup_enables) && $stable(port_drive_strength))
		else $error("Write to unmapped address changed a register.");

	peripheral_error_a: assert property (
		setup_phase && peripheral_mode |=> pslverr && pready)
		else $error("Peripheral mode access did not report an error.");

	pullup_write_a: assert property (
		access_done && pwrite && hit_pullup
		|=> port_pullup_enables == $past(pwdata[7:0]))
		else $error("Pullup register write was lost.");

	input_only_a: assert property (
		port_pullup_enables[port_f]
		|=> pullup_pin[port_f] == ~$past(pin_is_output[port_f]))
		else $error("Port F pullups do not follow pin direction.");

	enable_off_a: assert property (
		!port_pullup_enables[port_h] |=> pullup_pin[port_h] == 8'h00)
		else $error("Port H pullups active while disabled.");

	port_e_mask_a: assert property (
		(pullup_pin[port_e] & 8'hF2) == 8'h00)
		else $error("Port E pullup on a pin without one.");

	data_bus_c_off_a: assert property (
		data_bus_c |=> pullup_pin[port_c] == 8'h00)
		else $error("Port C pullup active on data bus.");

	data_bus_d_off_a: assert property (
		data_bus_d |=> pullup_pin[port_d] == 8'h00)
		else $error("Port D pullup active on data bus.");

	address_bus_off_a: assert property (
		address_bus_a |=> pullup_pin[port_a] == 8'h00)
		else $error("Port A pullup active on address bus.");

	address_bus_b_off_a: assert property (
		address_bus_b |=> pullup_pin[port_b] == 8'h00)
		else $error("Port B pullup active on address bus.");

	special_lock_a: assert property (
		access_done && pwrite && hit_drive && special_mode
		|=> $stable(port_drive_strength))
		else $error("Drive register written in special mode.");

	shared_drive_a: assert property (
		##1 low_drive_port[1] == low_drive_port[0]
		&& low_drive_port[0] == $past(port_drive_strength[0]))
		else $error("Ports A and B drive select mismatch.");

	port_j_drive_a: assert property (
		##1 low_drive_port[8] == $past(port_drive_strength[7]))
		else $error("Port J drive select does not follow register.");

	pullup_read_c: cover property (
		access_done && !pwrite && hit_pullup);
	drive_write_c: cover property (
		access_done && pwrite && hit_drive && !special_mode);
	peripheral_c: cover property (
		access_done && peripheral_mode && pslverr);
	bus_override_c: cover property (
		port_pullup_enables[port_d] && data_bus_d);
	special_write_c: cover property (
		access_done && pwrite && hit_drive && special_mode);

	// Bus answer: no wait state after any setup cycle, so a
	// master that waits for ready never stalls and never takes a stale
	// answer left over from the previous transfer.
	ready_after_setup_a: assert property (
		setup_phase |=> pready)
		else $error("No ready in the cycle after setup.");

	ready_single_a: assert property (
		pready |=> !pready)
		else $error("Ready stood for more than one cycle.");

	// Error and data lines stay quiet whenever no answer is given.
	idle_quiet_a: assert property (
		!pready |-> !pslverr && prdata == 32'h0000_0000)
		else $error("Answer lines active outside an access cycle.");

	mapped_no_error_a: assert property (
		setup_phase && (setup_pullup || setup_drive) |=> !pslverr)
		else $error("Mapped register access reported an error.");

	// Read data carries the register value seen at the setup edge.
	pullup_read_a: assert property (
		setup_phase && !pwrite && setup_pullup
		|=> prdata == {24'h00_0000, $past(port_pullup_enables)})
		else $error("Pullup register read returned a wrong value.");

	drive_read_a: assert property (
		setup_phase && !pwrite && setup_drive
		|=> prdata == {24'h00_0000, $past(port_drive_strength)})
		else $error("Drive register read returned a wrong value.");

	// A hidden register must not leak its contents in peripheral mode.
	peripheral_read_a: assert property (
		setup_phase && peripheral_mode |=> prdata == 32'h0000_0000)
		else $error("Peripheral mode read returned data.");

	// Normal modes must let every drive write through.
	drive_write_a: assert property (
		access_done && pwrite && hit_drive && !special_mode
		|=> port_drive_strength == $past(pwdata[7:0]))
		else $error("Drive register write was lost in a normal mode.");

	// Port E only ever pulls its three input-capable pins.
	port_e_input_a: assert property (
		port_pullup_enables[port_e]
		|=> pullup_pin[port_e]
		== (~$past(pin_is_output[port_e]) & `PORT_E_PULL_MASK))
		else $error("Port E pullups do not follow pin direction.");

	// Per port: outputs never pulled, enable and direction followed,
	// and a cleared enable leaves the whole port without pullups.
	genvar q;
	generate
		for (q = 0; q < 8; q++) begin : g_check
			output_no_pull_a: assert property (
				##1 (pullup_pin[q] & $past(pin_is_output[q])) == 8'h00)
				else $error("Pullup active on an output pin.");

			pull_follow_a: assert property (
				port_pullup_enables[q] && !bus_use[q]
				|=> pullup_pin[q] == (~$past(pin_is_output[q])
				& ((q == 4) ? `PORT_E_PULL_MASK : 8'hFF)))
				else $error("Pullups do not follow enable and direction.");

			port_off_a: assert property (
				!port_pullup_enables[q] |=> pullup_pin[q] == 8'h00)
				else $error("Pullups active on a disabled port.");
		end
	endgenerate

	// Each single-port drive select lands on its own output one edge
	// later; ports C to H are checked here, port J above.
	genvar b;
	generate
		for (b = 1; b < 7; b++) begin : g_drive_check
			port_drive_a: assert property (
				##1 low_drive_port[b + 1] == $past(port_drive_strength[b]))
				else $error("Port drive select does not follow register.");
		end
	endgenerate

endmodule

// ===== test/port_pad_pullup_drive_control_bench.sv
`timescale 1ns/1ps
`include "port_pad_params.svh"

module port_pad_pullup_drive_control_bench;
	import port_pad_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic peripheral_mode, special_mode;
	logic address_bus_a, address_bus_b, data_bus_c, data_bus_d;
	pin_matrix_type pin_is_output, pullup_pin;
	logic [8:0] low_drive_port;
	int mismatches, total_checks;

	port_pad_pullup_drive_control i_port_pad_pullup_drive_control (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.peripheral_mode(peripheral_mode), .special_mode(special_mode),
		.pin_is_output(pin_is_output), .address_bus_a(address_bus_a),
		.address_bus_b(address_bus_b), .data_bus_c(data_bus_c),
		.data_bus_d(data_bus_d), .pullup_pin(pullup_pin),
		.low_drive_port(low_drive_port));

	// Free-running 50 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Compare and count; a mismatch is reported at once.
	task automatic check(input logic [31:0] act, input logic [31:0] exp);
		total_checks++;
		if (act !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
		end
	endtask

	// Single place where the run ends.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One APB transfer; the request is held until pready is seen high.
	task automatic xfer(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (pready !== 1'b1) begin
			mismatches++;
			finish_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// Pins are registered, so give the outputs a few edges to follow.
	task automatic check_pull(input logic [7:0] en);
		logic [7:0] m;
		logic busy;
		repeat (3) @(posedge pclk);
		for (int p = 0; p < 8; p++) begin
			m = (p == 4) ? `PORT_E_PULL_MASK : 8'hFF;
			busy = (p == 0 && address_bus_a) || (p == 1 && address_bus_b) ||
				(p == 2 && data_bus_c) || (p == 3 && data_bus_d);
			check(32'(pullup_pin[p]),
				32'(en[p] && !busy ? ~pin_is_output[p] & m : 8'h00));
		end
	endtask

	// Both registers come out of reset at their documented values.
	task automatic reset_values();
		xfer(1'b0, `PULLUP_OFFSET, 32'h0);
		check(rd, 32'(`PULLUP_RESET));
		xfer(1'b0, `DRIVE_OFFSET, 32'h0);
		check(rd, 32'(`DRIVE_RESET));
	endtask

	// Per-pin pullups with mixed directions, then external bus ports.
	task automatic pullup_scenario();
		pin_is_output <= 64'h0123_4567_89AB_CDEF;
		xfer(1'b1, `PULLUP_OFFSET, 32'hFFFF_FF5A);
		xfer(1'b0, `PULLUP_OFFSET, 32'h0);
		check(rd, 32'h5A);
		check_pull(8'h5A);
		xfer(1'b1, `PULLUP_OFFSET, 32'hFF);
		address_bus_a <= 1'b1;
		data_bus_c <= 1'b1;
		check_pull(8'hFF);
		address_bus_b <= 1'b1;
		data_bus_d <= 1'b1;
		check_pull(8'hFF);
	endtask

	// Drive bits map to ports; special mode drops writes silently.
	task automatic drive_scenario();
		xfer(1'b1, `DRIVE_OFFSET, 32'h81);
		repeat (3) @(posedge pclk);
		check(32'(low_drive_port), 32'h103);
		pin_is_output <= '0;
		xfer(1'b1, `DRIVE_OFFSET, 32'h7E);
		repeat (3) @(posedge pclk);
		check(32'(low_drive_port), 32'h0FC);
		special_mode <= 1'b1;
		xfer(1'b1, `DRIVE_OFFSET, 32'h81);
		xfer(1'b0, `DRIVE_OFFSET, 32'h0);
		check(rd, 32'h7E);
		check(32'(err), 32'h0);
		xfer(1'b1, `PULLUP_OFFSET, 32'h3C);
		xfer(1'b0, `PULLUP_OFFSET, 32'h0);
		check(rd, 32'h3C);
		special_mode <= 1'b0;
	endtask

	// Peripheral mode unmaps both registers; unmapped space errors.
	task automatic map_scenario();
		peripheral_mode <= 1'b1;
		xfer(1'b1, `PULLUP_OFFSET, 32'h0);
		check(32'(err), 32'h1);
		xfer(1'b0, `DRIVE_OFFSET, 32'h0);
		check(32'(err), 32'h1);
		check(rd, 32'h0);
		peripheral_mode <= 1'b0;
		xfer(1'b0, `PULLUP_OFFSET, 32'h0);
		check(rd, 32'h3C);
		xfer(1'b0, 12'h008, 32'h0);
		check(32'(err), 32'h1);
		check(rd, 32'h0);
	endtask

	// A reset in mid-run clears both registers, the drive selects and the port F pullups.
	task automatic reset_scenario();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check(32'(low_drive_port), 32'h0);
		check(32'(pullup_pin[port_f]), 32'h0);
		presetn <= 1'b1;
		reset_values();
	endtask

	// Main sequence: reset held for 20 cycles, then each scenario.
	initial begin
		mismatches = 0;
		total_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		peripheral_mode = 1'b0;
		special_mode = 1'b0;
		pin_is_output = '0;
		address_bus_a = 1'b0;
		address_bus_b = 1'b0;
		data_bus_c = 1'b0;
		data_bus_d = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		reset_values();
		pullup_scenario();
		drive_scenario();
		map_scenario();
		reset_scenario();
		finish_test();
	end
endmodule
